// >>> logic/qadc_pkg.sv
// shared constants, field layouts and carriers of the quad converter map
package qadc_pkg;

	// ==========================================================
	// map layout
	localparam int ADDR_W = 16;
	localparam int NUM_CH = 4;
	localparam logic [15:0] PAGE_RESULT_BASE = 16'h0000;
	localparam logic [15:0] PAGE_CTRL_BASE = 16'h0008;
	localparam logic [15:0] PAGE_ALARM_BASE = 16'h0010;
	localparam logic [15:0] MAP_END = 16'h0018;

	// ==========================================================
	// reset values
	localparam logic [7:0] CTRL_FIRST_RESET = 8'h08;
	localparam logic [7:0] CTRL_SECOND_RESET = 8'h8c;
	localparam logic [7:0] LOW_THR_RESET = 8'h00;
	localparam logic [7:0] HIGH_THR_RESET = 8'hff;
	localparam logic [15:0] RESULT_RESET = 16'h0000;

	// ==========================================================
	// field positions
	localparam int OE_POS = 7;
	localparam int OC_POS = 6;
	localparam int RES_LSB = 0;
	localparam int POR_POS = 7;
	localparam int AFH_POS = 5;
	localparam int AFL_POS = 4;
	localparam int AEH_POS = 3;
	localparam int AEL_POS = 2;
	localparam int IR_POS = 0;

	// ==========================================================
	// identity code
	localparam int ROM_BITS = 64;
	localparam int SERIAL_BITS = 48;
	localparam int CRC_INPUT_BITS = 56;
	// x^8+x^5+x^4+1, reflected for lsb-first shifting
	localparam logic [7:0] CRC_POLY_REFL = 8'h8c;
	localparam int CRC_SETTLE_MAX = 60;

	// ==========================================================
	// carriers
	typedef struct packed {
		logic output_enable;
		logic drain_output_level;
		logic [3:0] resolution;
	} qadc_ctrl_t;

	typedef struct packed {
		logic high_alarm_flag;
		logic low_alarm_flag;
		logic high_alarm_search_enable;
		logic low_alarm_search_enable;
		logic full_scale_select;
	} qadc_stat_t;

	typedef struct packed {
		logic valid;
		logic [1:0] channel;
		logic [15:0] value;
	} qadc_conv_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [15:0] addr;
		logic [7:0] data;
	} qadc_mem_req_t;

	typedef enum logic [1:0] {
		CRC_RUN = 2'b01,
		CRC_DONE = 2'b10
	} qadc_crc_state_t;

	function automatic qadc_ctrl_t qadc_ctrl_unpack(input logic [7:0] b);
		qadc_ctrl_t c;
		c.output_enable = b[OE_POS];
		c.drain_output_level = b[OC_POS];
		c.resolution = b[RES_LSB+:4];
		return c;
	endfunction

	function automatic qadc_stat_t qadc_stat_unpack(input logic [7:0] b);
		qadc_stat_t s;
		s.high_alarm_flag = b[AFH_POS];
		s.low_alarm_flag = b[AFL_POS];
		s.high_alarm_search_enable = b[AEH_POS];
		s.low_alarm_search_enable = b[AEL_POS];
		s.full_scale_select = b[IR_POS];
		return s;
	endfunction

	// kept bits of a result for a resolution code, 0 meaning all 16
	function automatic logic [15:0] qadc_res_mask(input logic [3:0] r);
		logic [15:0] m;
		m = (r == 4'h0) ? 16'hffff : ~(16'hffff >> r);
		return m;
	endfunction

endpackage

// >>> logic/qadc_register_map.sv
// register bank, identity code and mode logic of the quad converter
`timescale 1ns/1ps

// Operation
// - identity is family byte, 48-bit serial, then CRC over first 56 bits
// - CRC x^8+x^5+x^4+1, zero start, family lsb shifted in first
// - every byte on the line travels least significant bit first
// - fast selection byte received at standard speed switches to fast mode
// - registers fill 24 consecutive bytes as three 8-byte pages
// - page zero holds 16-bit results, channel A lowest, low byte first
// - all result bytes are zero after power-on
// - result msb fixed; unused low result bits read zero
// - four-bit resolution code gives bit count, zero meaning sixteen
// - unused control and status bits read zero and ignore ones
// - output enable low means analog input; else level 0 drives drain
// - enabling the drain output never blocks conversions
// - full-scale select bit picks 2.55V or 5.10V full scale
// - alarm enables make alarms answer conditional search
// - alarm flags follow latest conversion; master may clear them
// - power-on sets the power flag; while set, always answer search
// - writing 1 to the power flag joins search, starts no reset
// - power flag is one device bit, last second-byte write wins
// - control bytes reset to 08h and 8Ch
// - 8-bit thresholds compared with top eight result bits
// - low threshold resets to 00h, high threshold to FFh
module qadc_register_map #(
	parameter logic [7:0] FAMILY_CODE = 8'h5a, // arbitrary value
	parameter logic [47:0] SERIAL_NUMBER = 48'h0123_4567_89ab, // arbitrary
	parameter logic [7:0] FAST_SKIP_CMD = 8'h3c,
	parameter logic [7:0] FAST_MATCH_CMD = 8'h69
) (
	input wire logic clock,
	input wire logic rst,
	input wire qadc_pkg::qadc_mem_req_t mem_req,
	output logic [7:0] rd_data,
	input wire qadc_pkg::qadc_conv_t conv,
	input wire logic cmd_done,
	input wire logic [7:0] cmd_byte,
	input wire logic [5:0] rom_index,
	output logic rom_bit,
	output logic rom_ready,
	output logic fast_mode,
	output logic [3:0] drain_out,
	output logic [3:0] drain_oe,
	output logic [3:0] full_scale_select,
	output logic cond_search_respond
);

	// ==========================================================
	// storage
	logic [15:0] result_reg [4];
	qadc_pkg::qadc_ctrl_t ctrl_reg [4];
	qadc_pkg::qadc_stat_t stat_reg [4];
	logic [7:0] low_thr_reg [4];
	logic [7:0] high_thr_reg [4];
	logic por_reg;
	logic [7:0] rd_data_reg;
	logic rom_bit_reg;
	logic fast_mode_reg;
	logic [3:0] drain_oe_reg;
	logic [3:0] drain_out_reg;
	logic [3:0] full_scale_reg;
	logic cond_search_reg;

	// ==========================================================
	// address decode
	logic [4:0] byte_idx;
	logic [1:0] wr_ch;
	logic wr_first;
	logic wr_second;
	logic wr_low_thr;
	logic wr_high_thr;
	logic [15:0] conv_mask;
	logic [15:0] conv_masked;
	logic [7:0] thr_mask;
	logic conv_high;
	logic conv_low;

	assign byte_idx = mem_req.addr[4:0];
	assign wr_ch = mem_req.addr[2:1];
	assign wr_first = mem_req.wr && mem_req.addr >= qadc_pkg::PAGE_CTRL_BASE
		&& mem_req.addr < qadc_pkg::PAGE_ALARM_BASE && !mem_req.addr[0];
	assign wr_second = mem_req.wr && mem_req.addr >= qadc_pkg::PAGE_CTRL_BASE
		&& mem_req.addr < qadc_pkg::PAGE_ALARM_BASE && mem_req.addr[0];
	assign wr_low_thr = mem_req.wr && mem_req.addr >= qadc_pkg::PAGE_ALARM_BASE
		&& mem_req.addr < qadc_pkg::MAP_END && !mem_req.addr[0];
	assign wr_high_thr = mem_req.wr
		&& mem_req.addr >= qadc_pkg::PAGE_ALARM_BASE
		&& mem_req.addr < qadc_pkg::MAP_END && mem_req.addr[0];

	// ==========================================================
	// conversion path
	// conversions run regardless of the drain output
	assign conv_mask = qadc_pkg::qadc_res_mask(ctrl_reg[conv.channel].resolution);
	assign conv_masked = conv.value & conv_mask;
	// thresholds lose the bits below the resolution too
	assign thr_mask = conv_mask[15:8];
	assign conv_high = conv_masked[15:8] > (high_thr_reg[conv.channel] & thr_mask);
	assign conv_low = conv_masked[15:8] < (low_thr_reg[conv.channel] & thr_mask);

	always_ff @(posedge clock) begin
		if (rst) begin
			for (int i = 0; i < 4; i++) begin
				result_reg[i] <= qadc_pkg::RESULT_RESET;
			end
		end else if (conv.valid) begin
			result_reg[conv.channel] <= conv_masked;
		end
	end

	// ==========================================================
	// control bytes
	always_ff @(posedge clock) begin
		if (rst) begin
			for (int i = 0; i < 4; i++) begin
				ctrl_reg[i] <= qadc_pkg::qadc_ctrl_unpack(qadc_pkg::CTRL_FIRST_RESET);
			end
		end else if (wr_first) begin
			// fixed-zero bits are not stored at all
			ctrl_reg[wr_ch] <= qadc_pkg::qadc_ctrl_unpack(mem_req.data);
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			for (int i = 0; i < 4; i++) begin
				stat_reg[i] <= qadc_pkg::qadc_stat_unpack(qadc_pkg::CTRL_SECOND_RESET);
			end
		end else begin
			if (wr_second) begin
				stat_reg[wr_ch].full_scale_select <=
					mem_req.data[qadc_pkg::IR_POS];
				stat_reg[wr_ch].low_alarm_search_enable <=
					mem_req.data[qadc_pkg::AEL_POS];
				stat_reg[wr_ch].high_alarm_search_enable <=
					mem_req.data[qadc_pkg::AEH_POS];
				// a one leaves the flag, a zero clears it
				stat_reg[wr_ch].low_alarm_flag <= stat_reg[wr_ch].low_alarm_flag
					& mem_req.data[qadc_pkg::AFL_POS];
				stat_reg[wr_ch].high_alarm_flag <= stat_reg[wr_ch].high_alarm_flag
					& mem_req.data[qadc_pkg::AFH_POS];
			end
			// placed last so a conversion beats a same-cycle clear
			if (conv.valid) begin
				stat_reg[conv.channel].high_alarm_flag <= conv_high;
				stat_reg[conv.channel].low_alarm_flag <= conv_low;
			end
		end
	end

	// one bit for the whole device, any channel's second byte writes it
	always_ff @(posedge clock) begin
		if (rst) begin
			por_reg <= qadc_pkg::CTRL_SECOND_RESET[qadc_pkg::POR_POS];
		end else if (wr_second) begin
			// a written one only flags, it starts nothing
			por_reg <= mem_req.data[qadc_pkg::POR_POS];
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			for (int i = 0; i < 4; i++) begin
				low_thr_reg[i] <= qadc_pkg::LOW_THR_RESET;
				high_thr_reg[i] <= qadc_pkg::HIGH_THR_RESET;
			end
		end else begin
			if (wr_low_thr) begin
				low_thr_reg[wr_ch] <= mem_req.data;
			end
			if (wr_high_thr) begin
				high_thr_reg[wr_ch] <= mem_req.data;
			end
		end
	end

	// ==========================================================
	// read port
	always_ff @(posedge clock) begin
		if (rst) begin
			rd_data_reg <= 8'h00;
		end else if (mem_req.rd) begin
			rd_data_reg <= 8'h00;
			if (mem_req.addr < qadc_pkg::PAGE_CTRL_BASE) begin
				rd_data_reg <= byte_idx[0] ? result_reg[byte_idx[2:1]][15:8]
					: result_reg[byte_idx[2:1]][7:0];
			end else if (mem_req.addr < qadc_pkg::PAGE_ALARM_BASE) begin
				if (!byte_idx[0]) begin
					rd_data_reg <= {ctrl_reg[byte_idx[2:1]].output_enable,
						ctrl_reg[byte_idx[2:1]].drain_output_level, 2'b00,
						ctrl_reg[byte_idx[2:1]].resolution};
				end else begin
					rd_data_reg <= {por_reg, 1'b0,
						stat_reg[byte_idx[2:1]].high_alarm_flag,
						stat_reg[byte_idx[2:1]].low_alarm_flag,
						stat_reg[byte_idx[2:1]].high_alarm_search_enable,
						stat_reg[byte_idx[2:1]].low_alarm_search_enable, 1'b0,
						stat_reg[byte_idx[2:1]].full_scale_select};
				end
			end else if (mem_req.addr < qadc_pkg::MAP_END) begin
				rd_data_reg <= byte_idx[0] ? high_thr_reg[byte_idx[2:1]]
					: low_thr_reg[byte_idx[2:1]];
			end
		end
	end

	// ==========================================================
	// channel outputs and search answer
	logic [3:0] alarm_hit;

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			alarm_hit[i] = (stat_reg[i].high_alarm_flag
				&& stat_reg[i].high_alarm_search_enable)
				|| (stat_reg[i].low_alarm_flag
				&& stat_reg[i].low_alarm_search_enable);
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			drain_oe_reg <= 4'h0;
			drain_out_reg <= 4'h0;
			full_scale_reg <= 4'h0;
		end else begin
			drain_out_reg <= 4'h0;
			for (int i = 0; i < 4; i++) begin
				drain_oe_reg[i] <= ctrl_reg[i].output_enable
					&& !ctrl_reg[i].drain_output_level;
				full_scale_reg[i] <= stat_reg[i].full_scale_select;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			cond_search_reg <= 1'b0;
		end else begin
			cond_search_reg <= por_reg || (|alarm_hit);
		end
	end

	// ==========================================================
	// identity code and its CRC
	// crc is worked out serially after reset, so no table sits in logic
	qadc_pkg::qadc_crc_state_t crc_state_reg;
	logic [7:0] crc_reg;
	logic [5:0] crc_idx_reg;
	logic [55:0] id_body;
	logic crc_fb;
	logic [63:0] rom_word;

	assign id_body = {SERIAL_NUMBER, FAMILY_CODE};
	assign crc_fb = crc_reg[0] ^ id_body[crc_idx_reg];
	assign rom_word = {crc_reg, id_body};

	always_ff @(posedge clock) begin
		if (rst) begin
			crc_state_reg <= qadc_pkg::CRC_RUN;
			crc_reg <= 8'h00;
			crc_idx_reg <= 6'h00;
		end else begin
			case (crc_state_reg)
				qadc_pkg::CRC_RUN: begin
					crc_reg <= (crc_reg >> 1)
						^ (crc_fb ? qadc_pkg::CRC_POLY_REFL : 8'h00);
					crc_idx_reg <= crc_idx_reg + 6'h01;
					if (crc_idx_reg == 6'(qadc_pkg::CRC_INPUT_BITS - 1)) begin
						crc_state_reg <= qadc_pkg::CRC_DONE;
					end
				end
				qadc_pkg::CRC_DONE: begin
					crc_state_reg <= qadc_pkg::CRC_DONE;
				end
				default: begin
					crc_state_reg <= qadc_pkg::CRC_RUN;
				end
			endcase
		end
	end

	// index 0 is the family lsb, the first bit on the line
	always_ff @(posedge clock) begin
		if (rst) begin
			rom_bit_reg <= 1'b0;
		end else begin
			rom_bit_reg <= rom_word[rom_index];
		end
	end

	// ==========================================================
	// speed mode
	always_ff @(posedge clock) begin
		if (rst) begin
			fast_mode_reg <= 1'b0;
		end else if (cmd_done && !fast_mode_reg && (cmd_byte == FAST_SKIP_CMD
			|| cmd_byte == FAST_MATCH_CMD)) begin
			fast_mode_reg <= 1'b1;
		end
	end

	assign rd_data = rd_data_reg;
	assign rom_bit = rom_bit_reg;
	assign rom_ready = (crc_state_reg == qadc_pkg::CRC_DONE);
	assign fast_mode = fast_mode_reg;
	assign drain_out = drain_out_reg;
	assign drain_oe = drain_oe_reg;
	assign full_scale_select = full_scale_reg;
	assign cond_search_respond = cond_search_reg;

	// ==========================================================
	// assertions
	property p_result_reset;
		@(posedge clock) rst |=> result_reg[0] == 16'h0000
			&& result_reg[3] == 16'h0000;
	endproperty
	a_result_reset: assert property (p_result_reset)
		else $error("result not cleared by reset");

	property p_result_mask;
		@(posedge clock) disable iff (rst)
		conv.valid && conv.channel == 2'd0 |=> (result_reg[0]
			& ~qadc_pkg::qadc_res_mask(ctrl_reg[0].resolution)) == 16'h0000;
	endproperty
	a_result_mask: assert property (p_result_mask)
		else $error("unused result bits not zero");

	property p_fixed_zero;
		@(posedge clock) disable iff (rst)
		mem_req.rd && mem_req.addr == 16'h0009 |=> rd_data[6] == 1'b0
			&& rd_data[1] == 1'b0 && rd_data[7] == $past(por_reg);
	endproperty
	a_fixed_zero: assert property (p_fixed_zero)
		else $error("fixed zero bit read as one");

	property p_drain;
		@(posedge clock) disable iff (rst)
		wr_first && wr_ch == 2'd1 ##1 !wr_first [*1] |=>
			drain_oe[1] == ($past(mem_req.data[7], 2) && !$past(mem_req.data[6], 2));
	endproperty
	a_drain: assert property (p_drain)
		else $error("drain enable does not follow control");

	property p_por_write;
		@(posedge clock) disable iff (rst)
		wr_second |=> por_reg == $past(mem_req.data[7]);
	endproperty
	a_por_write: assert property (p_por_write)
		else $error("power flag missed last write");

	property p_cond_por;
		@(posedge clock) disable iff (rst)
		por_reg |=> cond_search_respond;
	endproperty
	a_cond_por: assert property (p_cond_por)
		else $error("power flag not answering search");

	property p_fast;
		@(posedge clock) disable iff (rst)
		cmd_done && cmd_byte == FAST_SKIP_CMD |=> fast_mode [*3];
	endproperty
	a_fast: assert property (p_fast)
		else $error("fast mode not entered");

	property p_crc_done;
		@(posedge clock) disable iff (rst)
		$fell(rst) |-> ##[55:57] rom_ready;
	endproperty
	a_crc_done: assert property (p_crc_done)
		else $error("identity crc not ready in time");

	property p_rom_lsb;
		@(posedge clock) disable iff (rst)
		rom_index == 6'd0 |=> rom_bit == FAMILY_CODE[0];
	endproperty
	a_rom_lsb: assert property (p_rom_lsb)
		else $error("identity not lsb first");

	property p_flag_wins;
		@(posedge clock) disable iff (rst)
		conv.valid && conv.channel == 2'd0 && conv_high
			&& wr_second && wr_ch == 2'd0 |=> stat_reg[0].high_alarm_flag;
	endproperty
	a_flag_wins: assert property (p_flag_wins)
		else $error("alarm lost to clear");

	property p_thr_reset;
		@(posedge clock) rst |=> low_thr_reg[2] == 8'h00
			&& high_thr_reg[2] == 8'hff;
	endproperty
	a_thr_reset: assert property (p_thr_reset)
		else $error("threshold reset wrong");

endmodule

// >>> sim/qadc_master_model.sv
// bus master model: selection commands, register and identity traffic
`timescale 1ns/1ps
module qadc_master_model #(
	parameter logic [7:0] PLAIN_CMD = 8'hc3
) (
	input wire logic clock,
	input wire logic rst,
	output qadc_pkg::qadc_mem_req_t mem_req,
	output logic cmd_done,
	output logic [7:0] cmd_byte,
	output logic [5:0] rom_index,
	input wire logic rom_bit,
	input wire logic [7:0] rd_data
);
	logic selected;

	initial begin
		mem_req = '0;
		cmd_done = 1'b0;
		cmd_byte = 8'h00;
		rom_index = 6'h00;
		selected = 1'b0;
	end

	always @(posedge clock) begin
		if (rst) begin
			selected <= 1'b0;
		end
	end

	// ==========================================================
	// selection and register access
	task automatic send_cmd(input logic [7:0] b);
		@(negedge clock);
		cmd_done = 1'b1;
		cmd_byte = b;
		@(negedge clock);
		cmd_done = 1'b0;
		// released byte must not look valid
		cmd_byte = ~b;
		selected = 1'b1;
	endtask

	task automatic reg_write(input logic [15:0] a, input logic [7:0] d);
		if (!selected) begin
			send_cmd(PLAIN_CMD);
		end
		@(negedge clock);
		mem_req.wr = 1'b1;
		mem_req.addr = a;
		mem_req.data = d;
		@(negedge clock);
		mem_req.wr = 1'b0;
		mem_req.addr = ~a;
		mem_req.data = ~d;
	endtask

	task automatic reg_read(input logic [15:0] a, output logic [7:0] d);
		if (!selected) begin
			send_cmd(PLAIN_CMD);
		end
		@(negedge clock);
		mem_req.rd = 1'b1;
		mem_req.addr = a;
		@(negedge clock);
		mem_req.rd = 1'b0;
		mem_req.addr = ~a;
		@(negedge clock);
		d = rd_data;
	endtask

	// ==========================================================
	// identity code, taken one bit every two cycles, first bit on the line first
	task automatic rom_read(output logic [63:0] code);
		for (int i = 0; i < 64; i++) begin
			@(negedge clock);
			rom_index = i[5:0];
			@(negedge clock);
			code[i] = rom_bit;
		end
	endtask

	function automatic logic [7:0] crc8(input logic [63:0] d, input int n);
		logic [7:0] acc;
		logic fb;
		acc = 8'h00;
		for (int i = 0; i < n; i++) begin
			fb = acc[0] ^ d[i];
			acc = acc >> 1;
			if (fb) begin
				acc = acc ^ 8'h8c;
			end
		end
		return acc;
	endfunction
endmodule

// >>> sim/testbench.sv
// self-checking bench of the quad converter register map
`timescale 1ns/1ps
`define chk(got, exp) begin \
	check_count++; \
	if ((got) !== (exp)) begin \
		error_cnt++; \
		$display("BAD t=%0t got=%h exp=%h", $time, got, exp); \
	end \
end
module testbench;
	localparam logic [7:0] FAM = 8'h3e; // arbitrary value
	localparam logic [47:0] SER = 48'h1a2b_3c4d_5e6f; // arbitrary value
	localparam logic [7:0] FSKIP = 8'h3c;
	localparam logic [7:0] FMATCH = 8'h69;
	localparam logic [7:0] PLAIN = 8'hc3;
	logic clock;
	logic rst;
	qadc_pkg::qadc_mem_req_t mem_req;
	qadc_pkg::qadc_conv_t conv;
	logic [7:0] rd_data;
	logic cmd_done;
	logic [7:0] cmd_byte;
	logic [5:0] rom_index;
	logic rom_bit;
	logic rom_ready;
	logic fast_mode;
	logic [3:0] drain_out;
	logic [3:0] drain_oe;
	logic [3:0] full_scale_select;
	logic cond_search_respond;
	logic [63:0] code;
	int error_cnt = 0;
	int check_count = 0;

	qadc_register_map #(.FAMILY_CODE(FAM), .SERIAL_NUMBER(SER),
		.FAST_SKIP_CMD(FSKIP), .FAST_MATCH_CMD(FMATCH)) i_dut (
		.clock(clock), .rst(rst), .mem_req(mem_req), .rd_data(rd_data),
		.conv(conv), .cmd_done(cmd_done), .cmd_byte(cmd_byte),
		.rom_index(rom_index), .rom_bit(rom_bit), .rom_ready(rom_ready),
		.fast_mode(fast_mode), .drain_out(drain_out), .drain_oe(drain_oe),
		.full_scale_select(full_scale_select),
		.cond_search_respond(cond_search_respond));

	qadc_master_model #(.PLAIN_CMD(PLAIN)) i_master (
		.clock(clock), .rst(rst), .mem_req(mem_req), .cmd_done(cmd_done),
		.cmd_byte(cmd_byte), .rom_index(rom_index), .rom_bit(rom_bit),
		.rd_data(rd_data));

	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	// ==========================================================
	// helpers
	task automatic tick(input int n);
		repeat (n) @(negedge clock);
	endtask

	task automatic do_reset;
		@(negedge clock);
		rst = 1'b1;
		tick(3);
		rst = 1'b0;
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		i_master.reg_write(a, d);
	endtask

	task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
		logic [7:0] d;
		i_master.reg_read(a, d);
		`chk(d, e)
	endtask

	// settles flags and the search answer before returning
	task automatic cv(input logic [1:0] ch, input logic [15:0] v);
		@(negedge clock);
		conv = {1'b1, ch, v};
		@(negedge clock);
		conv = {1'b0, ch, ~v};
		tick(2);
	endtask

	task automatic test_done;
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	initial begin
		#100000;
		error_cnt++;
		$display("BAD t=%0t watchdog expired", $time);
		test_done;
	end

	// ==========================================================
	// tests
	initial begin
		rst = 1'b1;
		conv = '0;
		tick(3);
		rst = 1'b0;
		for (int a = 0; a < 8; a++) rd_chk(a[15:0], 8'h00);
		for (int a = 8; a < 16; a++) rd_chk(a[15:0], a[0] ? 8'h8c : 8'h08);
		for (int a = 16; a < 24; a++) rd_chk(a[15:0], a[0] ? 8'hff : 8'h00);
		rd_chk(16'h18, 8'h00);
		`chk(cond_search_respond, 1'b1)
		`chk(drain_oe, 4'h0)
		$display("test reset_values done");

		wr(16'h0d, 8'h00);
		rd_chk(16'h09, 8'h0c);
		`chk(cond_search_respond, 1'b0)
		wr(16'h0f, 8'h80);
		tick(2);
		`chk(cond_search_respond, 1'b1)
		rd_chk(16'h0b, 8'h8c);
		wr(16'h09, 8'h00);
		$display("test power_flag done");

		wr(16'h08, 8'hff);
		rd_chk(16'h08, 8'hcf);
		`chk(drain_oe, 4'h0)
		wr(16'h08, 8'h80);
		tick(2);
		`chk(drain_oe, 4'h1)
		`chk(drain_out, 4'h0)
		wr(16'h0b, 8'hff);
		rd_chk(16'h0b, 8'h8d);
		`chk(full_scale_select, 4'h2)
		wr(16'h0b, 8'h00);
		tick(2);
		`chk(full_scale_select, 4'h0)
		$display("test control_bits done");

		cv(2'd0, 16'h1234);
		rd_chk(16'h00, 8'h34);
		rd_chk(16'h01, 8'h12);
		wr(16'h0a, 8'h04);
		cv(2'd1, 16'habcd);
		rd_chk(16'h02, 8'h00);
		rd_chk(16'h03, 8'ha0);
		wr(16'h0c, 8'h0f);
		cv(2'd2, 16'hffff);
		rd_chk(16'h04, 8'hfe);
		$display("test results done");

		wr(16'h0f, 8'h08);
		wr(16'h17, 8'h80);
		cv(2'd3, 16'h8100);
		rd_chk(16'h0f, 8'h28);
		`chk(cond_search_respond, 1'b1)
		cv(2'd3, 16'h8000);
		rd_chk(16'h0f, 8'h08);
		`chk(cond_search_respond, 1'b0)
		wr(16'h16, 8'h40);
		wr(16'h0f, 8'h04);
		cv(2'd3, 16'h8100);
		rd_chk(16'h0f, 8'h24);
		`chk(cond_search_respond, 1'b0)
		cv(2'd3, 16'h3f00);
		rd_chk(16'h0f, 8'h14);
		`chk(cond_search_respond, 1'b1)
		wr(16'h0f, 8'h14);
		rd_chk(16'h0f, 8'h14);
		wr(16'h0f, 8'h04);
		rd_chk(16'h0f, 8'h04);
		tick(2);
		`chk(cond_search_respond, 1'b0)
		// alarm and a clearing write in one cycle: the alarm must win
		wr(16'h11, 8'h10);
		fork
			wr(16'h09, 8'h00);
			cv(2'd0, 16'h2000);
		join
		rd_chk(16'h09, 8'h20);
		$display("test alarms done");

		`chk(rom_ready, 1'b1)
		i_master.rom_read(code);
		`chk(code[7:0], FAM)
		`chk(code[55:8], SER)
		`chk(code[63:56], i_master.crc8({8'h00, SER, FAM}, 56))
		`chk(i_master.crc8(code, 64), 8'h00)
		$display("test identity done");

		for (int k = 0; k < 2; k++) begin
			do_reset;
			`chk(fast_mode, 1'b0)
			i_master.send_cmd(PLAIN);
			tick(1);
			`chk(fast_mode, 1'b0)
			i_master.send_cmd(k ? FMATCH : FSKIP);
			tick(1);
			`chk(fast_mode, 1'b1)
		end
		$display("test fast_mode done");
		test_done;
	end
endmodule
